// >>> logic/ssr_pkg.sv
// Operation
// - Battery-on high when output runs from battery
// - Power-fail out follows input, low on battery
// - Reset asserts at once on low supply
// - Reset held 50/200 ms after supply recovers (internal timebase)
// - Watchdog timeout gives repeating reset pulses
// - Active-high reset is complement of reset
// - Low-line follows threshold with no hold
// - Low-line low when supply below battery
// - Stuck kick input drives reset and fault
// - Floating kick input disables watchdog
// - Every kick transition restarts the watchdog
// - Fault clears on kick or low-line falling
// - Chip-enable buffered, forced high on low supply
// - Select input chooses internal or external timebase
// - External timing counts fixed clock periods
// - Internal reset time 50 or 200 ms
// - Internal watchdog 1.6 s or 100 ms
// - First timeout after reset is long with internal timebase; external is always 1024 periods
// - Switchover hysteresis 70 mV up, 50 mV down
// - External clock divided by 64
// - Backup mode ignores inputs, fixed outputs
package ssr_pkg;

   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int PCNT_W = 17;
   localparam int EXT_PRESCALE = 64;
   localparam int XCNT_W = 6;

   localparam int RST_MIN_SHORT_MS = 35;
   localparam int RST_MIN_LONG_MS = 140;
   localparam int RST_SHORT_MS = 50;
   localparam int RST_LONG_MS = 200;
   localparam int WD_LONG_MS = 1600;
   localparam int WD_SHORT_MS = 100;

   localparam int RCNT_W = 8;
   localparam int WCNT_W = 11;
   localparam logic [RCNT_W-1:0] RST_SHORT_TICKS =
      RCNT_W'(RST_SHORT_MS * 1000 / TICK_TIME_US);
   localparam logic [RCNT_W-1:0] RST_LONG_TICKS =
      RCNT_W'(RST_LONG_MS * 1000 / TICK_TIME_US);
   localparam logic [WCNT_W-1:0] WD_LONG_TICKS =
      WCNT_W'(WD_LONG_MS * 1000 / TICK_TIME_US);
   localparam logic [WCNT_W-1:0] WD_SHORT_TICKS =
      WCNT_W'(WD_SHORT_MS * 1000 / TICK_TIME_US);

   // Counts of prescaled external periods
   localparam logic [RCNT_W-1:0] EXT_RST_SHORT_TICKS = 8'h10;
   localparam logic [RCNT_W-1:0] EXT_RST_LONG_TICKS = 8'h40;
   localparam logic [WCNT_W-1:0] EXT_WD_TICKS = 11'h400;

   // ==========================================
   // Kick input levels
   typedef enum logic [1:0] {
      KICK_FLOAT = 2'b00,
      KICK_LOW = 2'b01,
      KICK_HIGH = 2'b10
   } ssr_kick_t;

   // ==========================================
   // Carriers
   typedef struct packed {
      logic supplyLow;
      logic battRise;
      logic battHold;
      logic powerFailIn;
      logic kickHigh;
      logic kickLow;
      logic ceInN;
      logic timebaseSelect;
      logic timebaseExtIn;
      logic longVariant;
   } ssr_pins_t;

   typedef struct packed {
      logic batteryOnOut;
      logic powerFailOutN;
      logic resetOutN;
      logic resetOut;
      logic lowLineOutN;
      logic watchdogFaultOutN;
      logic ceOutN;
   } ssr_outs_t;

   typedef struct packed {
      logic battOn;
      logic rstAct;
      logic [RCNT_W-1:0] rstCnt;
      logic [WCNT_W-1:0] wdCnt;
      logic wdFirst;
      ssr_kick_t kickLvl;
      logic wdFault;
      logic lowPrev;
      ssr_outs_t outs;
   } ssr_state_t;

   localparam ssr_outs_t OUTS_BACKUP = '{
      batteryOnOut: 1'b1, powerFailOutN: 1'b0, resetOutN: 1'b0,
      resetOut: 1'b1, lowLineOutN: 1'b0, watchdogFaultOutN: 1'b1,
      ceOutN: 1'b1};

   localparam ssr_state_t STATE_RST = '{
      battOn: 1'b1, rstAct: 1'b1, rstCnt: '0, wdCnt: '0,
      wdFirst: 1'b1, kickLvl: KICK_FLOAT, wdFault: 1'b0,
      lowPrev: 1'b1, outs: OUTS_BACKUP};

endpackage

// >>> logic/ssr_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   // ==========================================
   // Two-stage synchronizer
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } ssr_sync_state_t;

   ssr_sync_state_t state_ff;
   ssr_sync_state_t nxt_state;

   always_comb begin
      nxt_state.meta = asyncIn;
      nxt_state.stable = state_ff.meta;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign syncOut = state_ff.stable;

endmodule
`default_nettype wire

// >>> logic/ssr_timebase.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_timebase #(
   parameter int TICK_CYCLES = ssr_pkg::TICK_CYCLES
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic extMode,
   input wire logic extLevel,
   output logic tick
);

   typedef struct packed {
      logic [ssr_pkg::PCNT_W-1:0] divCnt;
      logic [ssr_pkg::XCNT_W-1:0] extCnt;
      logic extPrev;
      logic modePrev;
      logic tick;
   } ssr_tb_state_t;

   ssr_tb_state_t state_ff;
   ssr_tb_state_t nxt_state;

   // ==========================================
   // Internal divider or external edge prescaler
   always_comb begin
      nxt_state = state_ff;
      nxt_state.tick = 1'b0;
      nxt_state.extPrev = extLevel;
      nxt_state.modePrev = extMode;
      if (extMode != state_ff.modePrev) begin
         nxt_state.divCnt = '0;
         nxt_state.extCnt = '0;
      end else if (extMode) begin
         if (extLevel && !state_ff.extPrev) begin
            nxt_state.extCnt = state_ff.extCnt + 1'b1;
            if (state_ff.extCnt ==
                  ssr_pkg::XCNT_W'(ssr_pkg::EXT_PRESCALE - 1)) begin
               nxt_state.tick = 1'b1;
            end
         end
      end else if (state_ff.divCnt ==
            ssr_pkg::PCNT_W'(TICK_CYCLES - 1)) begin
         nxt_state.divCnt = '0;
         nxt_state.tick = 1'b1;
      end else begin
         nxt_state.divCnt = state_ff.divCnt + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign tick = state_ff.tick;

endmodule
`default_nettype wire

// >>> logic/ssr_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_supervisor #(
   parameter int TICK_CYCLES = ssr_pkg::TICK_CYCLES
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic supplyLowIn,
   input wire logic battRiseIn,
   input wire logic battHoldIn,
   input wire logic powerFailIn,
   input wire logic watchdogKickInHigh,
   input wire logic watchdogKickInLow,
   input wire logic ceInN,
   input wire logic timebaseSelect,
   input wire logic timebaseExtIn,
   input wire logic longResetVariant,
   output logic batteryOnOut,
   output logic powerFailOutN,
   output logic resetOutN,
   output logic resetOut,
   output logic lowLineOutN,
   output logic watchdogFaultOutN,
   output logic ceOutN
);

   // ==========================================
   // Input synchronization
   ssr_pkg::ssr_pins_t pinsRaw;
   ssr_pkg::ssr_pins_t pins;
   logic tick;
   logic extMode;

   always_comb begin
      pinsRaw.supplyLow = supplyLowIn;
      pinsRaw.battRise = battRiseIn;
      pinsRaw.battHold = battHoldIn;
      pinsRaw.powerFailIn = powerFailIn;
      pinsRaw.kickHigh = watchdogKickInHigh;
      pinsRaw.kickLow = watchdogKickInLow;
      pinsRaw.ceInN = ceInN;
      pinsRaw.timebaseSelect = timebaseSelect;
      pinsRaw.timebaseExtIn = timebaseExtIn;
      pinsRaw.longVariant = longResetVariant;
   end

   ssr_sync #(
      .WIDTH($bits(ssr_pkg::ssr_pins_t))
   ) u_sync (
      .clock(clock),
      .srst(srst),
      .asyncIn(pinsRaw),
      .syncOut(pins)
   );

   // ==========================================
   // Timebase
   assign extMode = !pins.timebaseSelect;

   ssr_timebase #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timebase (
      .clock(clock),
      .srst(srst),
      .extMode(extMode),
      .extLevel(pins.timebaseExtIn),
      .tick(tick)
   );

   // ==========================================
   // Period selection
   function automatic logic [ssr_pkg::RCNT_W-1:0] rstLimit(
         input logic ext,
         input logic longVar);
      logic [ssr_pkg::RCNT_W-1:0] lim;
      lim = longVar ? ssr_pkg::RST_LONG_TICKS
                    : ssr_pkg::RST_SHORT_TICKS;
      if (ext) begin
         lim = longVar ? ssr_pkg::EXT_RST_LONG_TICKS
                       : ssr_pkg::EXT_RST_SHORT_TICKS;
      end
      return lim;
   endfunction

   function automatic logic [ssr_pkg::WCNT_W-1:0] wdLimit(
         input logic ext,
         input logic first,
         input logic extLevel);
      logic [ssr_pkg::WCNT_W-1:0] lim;
      lim = extLevel ? ssr_pkg::WD_LONG_TICKS
                     : ssr_pkg::WD_SHORT_TICKS;
      if (ext) begin
         lim = ssr_pkg::EXT_WD_TICKS;
      end
      if (first) begin
         lim = ext ? ssr_pkg::EXT_WD_TICKS
                   : ssr_pkg::WD_LONG_TICKS;
      end
      return lim;
   endfunction

   // ==========================================
   // State
   ssr_pkg::ssr_state_t state_ff;
   ssr_pkg::ssr_state_t nxt_state;

   ssr_pkg::ssr_kick_t kickNow;
   logic lowSupply;
   logic kickEdge;
   logic wdEnable;
   logic lowFall;
   logic [ssr_pkg::RCNT_W-1:0] rstLim;
   logic [ssr_pkg::WCNT_W-1:0] wdLim;

   always_comb begin
      if (pins.kickHigh) begin
         kickNow = ssr_pkg::KICK_HIGH;
      end else if (pins.kickLow) begin
         kickNow = ssr_pkg::KICK_LOW;
      end else begin
         kickNow = ssr_pkg::KICK_FLOAT;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_state.kickLvl = kickNow;

      // Switchover with hysteresis
      if (state_ff.battOn) begin
         if (pins.battRise) begin
            nxt_state.battOn = 1'b0;
         end
      end else if (!pins.battHold) begin
         nxt_state.battOn = 1'b1;
      end

      lowSupply = pins.supplyLow || state_ff.battOn;
      nxt_state.lowPrev = lowSupply;
      lowFall = lowSupply && !state_ff.lowPrev;

      kickEdge = (kickNow != state_ff.kickLvl) &&
                 (kickNow != ssr_pkg::KICK_FLOAT) &&
                 (state_ff.kickLvl != ssr_pkg::KICK_FLOAT);
      wdEnable = (kickNow != ssr_pkg::KICK_FLOAT) && !lowSupply;

      rstLim = rstLimit(extMode, pins.longVariant);
      wdLim = wdLimit(extMode, state_ff.wdFirst, pins.timebaseExtIn);

      // Reset pulse generator
      if (lowSupply) begin
         nxt_state.rstAct = 1'b1;
         nxt_state.rstCnt = '0;
         nxt_state.wdFirst = 1'b1;
      end else if (state_ff.rstAct && tick) begin
         if (state_ff.rstCnt == rstLim - 1'b1) begin
            nxt_state.rstAct = 1'b0;
         end else begin
            nxt_state.rstCnt = state_ff.rstCnt + 1'b1;
         end
      end

      // Watchdog counter
      if (!wdEnable || state_ff.rstAct) begin
         nxt_state.wdCnt = '0;
      end else if (kickEdge) begin
         nxt_state.wdCnt = '0;
         nxt_state.wdFirst = 1'b0;
      end else if (tick) begin
         if (state_ff.wdCnt == wdLim - 1'b1) begin
            nxt_state.wdCnt = '0;
            nxt_state.wdFault = 1'b1;
            nxt_state.rstAct = 1'b1;
            nxt_state.rstCnt = '0;
            nxt_state.wdFirst = 1'b1;
         end else begin
            nxt_state.wdCnt = state_ff.wdCnt + 1'b1;
         end
      end

      // Fault clear; a timeout never coincides with a kick
      if (kickEdge || lowFall || lowSupply) begin
         nxt_state.wdFault = 1'b0;
      end

      // Registered outputs
      if (nxt_state.battOn) begin
         nxt_state.outs = ssr_pkg::OUTS_BACKUP;
      end else begin
         nxt_state.outs.batteryOnOut = 1'b0;
         nxt_state.outs.powerFailOutN = pins.powerFailIn;
         nxt_state.outs.resetOutN = !nxt_state.rstAct;
         nxt_state.outs.resetOut = nxt_state.rstAct;
         nxt_state.outs.lowLineOutN = !pins.supplyLow;
         nxt_state.outs.watchdogFaultOutN = !nxt_state.wdFault;
         nxt_state.outs.ceOutN = pins.supplyLow ? 1'b1
                                                : pins.ceInN;
      end
      if (nxt_state.battOn) begin
         nxt_state.outs.lowLineOutN = 1'b0;
         nxt_state.outs.powerFailOutN = 1'b0;
         nxt_state.outs.batteryOnOut = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_ff <= ssr_pkg::STATE_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================
   // Outputs
   assign batteryOnOut = state_ff.outs.batteryOnOut;
   assign powerFailOutN = state_ff.outs.powerFailOutN;
   assign resetOutN = state_ff.outs.resetOutN;
   assign resetOut = state_ff.outs.resetOut;
   assign lowLineOutN = state_ff.outs.lowLineOutN;
   assign watchdogFaultOutN = state_ff.outs.watchdogFaultOutN;
   assign ceOutN = state_ff.outs.ceOutN;

endmodule
`default_nettype wire

// >>> sim/ssr_supervisor_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_supervisor_monitor #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic supplyLowIn,
   input wire logic battRiseIn,
   input wire logic battHoldIn,
   input wire logic powerFailIn,
   input wire logic watchdogKickInHigh,
   input wire logic watchdogKickInLow,
   input wire logic longResetVariant,
   input wire logic batteryOnOut,
   input wire logic powerFailOutN,
   input wire logic resetOutN,
   input wire logic resetOut,
   input wire logic lowLineOutN,
   input wire logic watchdogFaultOutN,
   input wire logic ceOutN
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   // ==========================================
   // Cycles spent in reset
   logic [31:0] lowCnt_ff;
   always_ff @(posedge clock) begin
      if (srst || resetOutN) begin
         lowCnt_ff <= '0;
      end else begin
         lowCnt_ff <= lowCnt_ff + 32'h1;
      end
   end

   // ==========================================
   // Checks
   rst_complement_a: assert property (resetOut == !resetOutN)
      else $error("reset outputs not complementary");
   backup_levels_a: assert property (batteryOnOut |->
      !powerFailOutN && !resetOutN && !lowLineOutN &&
      watchdogFaultOutN && ceOutN)
      else $error("backup levels wrong");
   supply_low_a: assert property (supplyLowIn [*4] |->
      !resetOutN && !lowLineOutN && ceOutN)
      else $error("low supply not flagged");
   supply_ok_a: assert property (
      (!supplyLowIn && battRiseIn && battHoldIn) [*5]
      |-> lowLineOutN && !batteryOnOut)
      else $error("low line not released");
   batt_drop_a: assert property (!battHoldIn [*5] |->
      !lowLineOutN && batteryOnOut)
      else $error("no switch to battery");
   pfo_high_a: assert property (
      (powerFailIn && battRiseIn && battHoldIn) [*5]
      |-> powerFailOutN)
      else $error("power fail out not high");
   pfo_low_a: assert property (!powerFailIn [*4] |-> !powerFailOutN)
      else $error("power fail out not low");
   fault_clear_a: assert property (
      !lowLineOutN && $past(!lowLineOutN) |-> watchdogFaultOutN)
      else $error("fault not cleared on low line");
   fault_cause_a: assert property ($fell(watchdogFaultOutN) |->
      !resetOutN &&
      ($past(watchdogKickInHigh, 3) || $past(watchdogKickInLow, 3)))
      else $error("fault without reset or with floating kick");
   reset_time_a: assert property ($rose(resetOutN) |-> lowCnt_ff >=
      32'((longResetVariant ? 199 : 49) * TICK_CYCLES))
      else $error("reset pulse too short");

   cover property ($rose(resetOutN));
   cover property ($fell(watchdogFaultOutN));
   cover property ($fell(batteryOnOut));
endmodule
`default_nettype wire

// >>> sim/ssr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_host_model (
   input wire logic clock,
   input wire logic [1:0] mode,
   input wire logic [15:0] period,
   output logic watchdogKickInHigh,
   output logic watchdogKickInLow
);
   // Mode 0 floats, 1 kicks each period, 2 holds the last level
   logic lvl_ff = 1'b0;
   logic [15:0] cnt_ff = '0;
   always_ff @(posedge clock) begin
      cnt_ff <= (cnt_ff >= period) ? '0 : cnt_ff + 16'h1;
      if (mode == 2'h1 && cnt_ff >= period) begin
         lvl_ff <= !lvl_ff;
      end
   end
   assign watchdogKickInHigh = (mode != 2'h0) && lvl_ff;
   assign watchdogKickInLow = (mode != 2'h0) && !lvl_ff;
endmodule
`default_nettype wire

// >>> sim/ssr_supervisor_test.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_supervisor_test;
   localparam int TC = 5;
   // External clock toggles every 4 cycles, so 8 cycles per period
   localparam int EXT_SLACK = ssr_pkg::EXT_PRESCALE * 8;
   localparam int EXT_RST =
      int'(ssr_pkg::EXT_RST_SHORT_TICKS) * EXT_SLACK;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic supplyLowIn = 1'b1;
   logic battRiseIn = 1'b0;
   logic battHoldIn = 1'b0;
   logic powerFailIn = 1'b0;
   logic ceInN = 1'b1;
   logic timebaseExtIn = 1'b1;
   logic timebaseSelect = 1'b1;
   logic longResetVariant = 1'b0;
   logic [1:0] kickMode = 2'h0;
   logic [15:0] kickPeriod = 16'h0bb8;
   logic watchdogKickInHigh, watchdogKickInLow, batteryOnOut, powerFailOutN;
   logic resetOutN, resetOut, lowLineOutN, watchdogFaultOutN, ceOutN;
   int badCount = 0;
   int samplesChecked = 0;

   always #5 clock = !clock;

   ssr_host_model host (.clock, .mode(kickMode), .period(kickPeriod),
      .watchdogKickInHigh, .watchdogKickInLow);
   ssr_supervisor #(.TICK_CYCLES(TC)) DUT (.clock, .srst, .supplyLowIn,
      .battRiseIn, .battHoldIn, .powerFailIn, .watchdogKickInHigh,
      .watchdogKickInLow, .ceInN, .timebaseSelect, .timebaseExtIn,
      .longResetVariant, .batteryOnOut, .powerFailOutN, .resetOutN,
      .resetOut, .lowLineOutN, .watchdogFaultOutN, .ceOutN);

   // ==========================================
   // Helpers
   task automatic giveVerdict();
      $display("Checked %0d, errors %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check_bit(input logic got, input logic exp,
      input string what);
      samplesChecked++;
      if (got !== exp) begin
         badCount++;
         $display("Error at %0t: %s is %b", $time, what, got);
      end
   endtask
   task automatic check_span(input int got, input int lo, input int hi,
      input string what);
      samplesChecked++;
      if (got < lo || got > hi) begin
         badCount++;
         $display("Error at %0t: %s took %0d", $time, what, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wait_lvl(input bit fault, input logic lvl, input int lim,
      output int n);
      n = 0;
      while (((fault ? watchdogFaultOutN : resetOutN) !== lvl) &&
            n < lim) begin
         @(posedge clock);
         n++;
      end
   endtask

   // ==========================================
   // Sequence
   initial begin
      int n;
      void'($urandom(44677));
      cyc(16);
      srst <= 1'b0;
      cyc(2);
      check_bit(batteryOnOut, 1'b1, "backup battery flag");
      battRiseIn <= 1'b1;
      battHoldIn <= 1'b1;
      supplyLowIn <= 1'b0;
      cyc(5);
      check_bit(batteryOnOut, 1'b0, "battery flag");
      check_bit(lowLineOutN, 1'b1, "low line");
      wait_lvl(1'b0, 1'b1, 400 * TC, n);
      check_span(n, 48 * TC, 51 * TC, "short reset");
      repeat (20) begin
         ceInN <= 1'($urandom);
         powerFailIn <= 1'($urandom);
         cyc(4);
         check_bit(ceOutN, ceInN, "chip enable");
         check_bit(powerFailOutN, powerFailIn, "power fail");
      end
      longResetVariant <= 1'b1;
      ceInN <= 1'b0;
      supplyLowIn <= 1'b1;
      cyc(4);
      check_bit(resetOutN, 1'b0, "reset on dip");
      check_bit(resetOut, 1'b1, "active high reset");
      check_bit(ceOutN, 1'b1, "chip enable on dip");
      supplyLowIn <= 1'b0;
      cyc(4);
      check_bit(lowLineOutN, 1'b1, "low line back");
      wait_lvl(1'b0, 1'b1, 400 * TC, n);
      check_span(n, 198 * TC, 201 * TC, "long reset");
      kickMode <= 2'h1;
      repeat (6) begin
         cyc(2000);
         check_bit(watchdogFaultOutN, 1'b1, "fault while kicked");
      end
      kickMode <= 2'h2;
      wait_lvl(1'b1, 1'b0, 2000 * TC, n);
      check_span(n, 1000 * TC, 1601 * TC, "stuck kick");
      wait_lvl(1'b0, 1'b1, 400 * TC, n);
      wait_lvl(1'b0, 1'b0, 2000 * TC, n);
      check_span(n, 1390 * TC, 1610 * TC, "repeat pulse");
      kickMode <= 2'h1;
      kickPeriod <= 16'h00fa;
      timebaseExtIn <= 1'b0;
      // Kicks after release clear the long first interval
      wait_lvl(1'b0, 1'b1, 400 * TC, n);
      cyc(500);
      check_bit(watchdogFaultOutN, 1'b1, "fault after kick");
      kickMode <= 2'h2;
      wait_lvl(1'b1, 1'b0, 2000 * TC, n);
      check_span(n, 45 * TC, 101 * TC, "short timeout");
      wait_lvl(1'b0, 1'b1, 400 * TC, n);
      wait_lvl(1'b0, 1'b0, 2000 * TC, n);
      check_span(n, 1390 * TC, 1610 * TC, "long after reset");
      kickMode <= 2'h0;
      wait_lvl(1'b0, 1'b1, 400 * TC, n);
      wait_lvl(1'b0, 1'b0, 1700 * TC, n);
      check_span(n, 1700 * TC, 1700 * TC, "floating kick");
      powerFailIn <= 1'b1;
      battHoldIn <= 1'b0;
      battRiseIn <= 1'b0;
      cyc(5);
      check_bit(batteryOnOut, 1'b1, "on battery");
      check_bit(powerFailOutN, 1'b0, "power fail on battery");
      check_bit(lowLineOutN, 1'b0, "low line on battery");
      battHoldIn <= 1'b1;
      cyc(5);
      check_bit(batteryOnOut, 1'b1, "hysteresis hold");
      battRiseIn <= 1'b1;
      cyc(5);
      check_bit(batteryOnOut, 1'b0, "back on supply");
      // External timebase: dip, then count reset time in clock cycles
      longResetVariant <= 1'b0;
      timebaseSelect <= 1'b0;
      supplyLowIn <= 1'b1;
      cyc(4);
      supplyLowIn <= 1'b0;
      n = 0;
      while (resetOutN !== 1'b1 && n < 12000) begin
         timebaseExtIn <= !timebaseExtIn;
         cyc(4);
         n += 4;
      end
      check_span(n, EXT_RST - EXT_SLACK, EXT_RST + EXT_SLACK,
         "external reset");
      giveVerdict();
   end

   initial begin
      #800000;
      badCount++;
      giveVerdict();
   end
endmodule

bind ssr_supervisor ssr_supervisor_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (
   .clock, .srst, .supplyLowIn, .battRiseIn, .battHoldIn, .powerFailIn,
   .watchdogKickInHigh, .watchdogKickInLow, .longResetVariant, .batteryOnOut,
   .powerFailOutN, .resetOutN, .resetOut, .lowLineOutN, .watchdogFaultOutN,
   .ceOutN);
`default_nettype wire
